// file: core/dgc_command.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module dgc_command #(
  parameter int NUM_CH = dgc_pkg::NUM_CH,
  parameter int NUM_QSEL = dgc_pkg::NUM_QSEL
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Transmit channels
  input wire logic [NUM_CH-1:0] hold_seen_i,
  output logic [NUM_CH-1:0] fetch_req_o,
  input wire logic [NUM_CH-1:0] fetch_done_i,
  input wire logic [NUM_CH-1:0] fetch_hold_i,
  output logic [NUM_CH-1:0] advance_o,
  // Action request execution
  input wire logic [3:0] ch_cmd_i,
  output logic queue_load_o,
  output logic [NUM_QSEL-1:0] queue_sel_o,
  output logic [3:0] ch_cmd_o,
  input wire logic action_done_i,
  input wire logic action_fail_i,
  output logic request_irq_mask_o
);
  typedef enum logic [1:0] {
    DGC_IDLE = 2'b01,
    DGC_BUSY = 2'b10
  } dgc_ar_state_e;
  typedef struct packed {
    logic [NUM_CH-1:0] tx_poll;
    logic irq_mask;
    logic trigger;
    logic [NUM_QSEL-1:0] qsel;
    logic mode;
    logic done_flag;
    logic fail_flag;
    dgc_ar_state_e ar_st;
    logic load;
    logic [NUM_QSEL-1:0] qsel_out;
    logic [3:0] cmd_out;
    logic [31:0] rdata;
  } dgc_top_s;
  dgc_top_s s_reg, s_next;
  logic rst_b;
  logic [NUM_CH-1:0] ch_halted;
  logic [NUM_CH-1:0] poll_go;
  logic wr_cmd, wr_status;
  logic [1:0] rst_sync_reg;
  logic rd_cmd, rd_status, wr_qsel, wr_mode;
  assign rst_b = rst_sync_reg[1];
  // Decodes are shared by the update logic and the checks so both follow one address map.
  assign wr_cmd = wr_i && (addr_i == dgc_pkg::CMD_OFFSET);
  assign wr_status = wr_i && (addr_i == dgc_pkg::STATUS_OFFSET);
  assign rd_cmd = rd_i && (addr_i == dgc_pkg::CMD_OFFSET);
  assign rd_status = rd_i && (addr_i == dgc_pkg::STATUS_OFFSET);
  assign wr_qsel = wr_i && (addr_i == dgc_pkg::QSEL_OFFSET);
  assign wr_mode = wr_i && (addr_i == dgc_pkg::MODE_OFFSET);
  assign poll_go = s_reg.tx_poll & ch_halted & {NUM_CH{s_reg.mode == dgc_pkg::MODE_HOLD}};
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      dgc_tx_channel u_ch (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b),
        .poll_i(poll_go[g]),
        .hold_seen_i(hold_seen_i[g]),
        .fetch_req_o(fetch_req_o[g]),
        .fetch_done_i(fetch_done_i[g]),
        .fetch_hold_i(fetch_hold_i[g]),
        .halted_o(ch_halted[g]),
        .advance_o(advance_o[g])
      );
    end
  endgenerate
  // Reset release synchroniser runs on the raw reset; all other state uses the synchronised copy.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  always_comb begin
    s_next = s_reg;
    s_next.rdata = 32'h0;
    s_next.load = 1'b0;
    // Poll bits are one-shot: they clear next cycle whether acted on or dropped.
    s_next.tx_poll = '0;
    s_next.trigger = 1'b0;
    if (wr_cmd) begin
      s_next.tx_poll = wdata_i[dgc_pkg::POS_POLL_LO +: NUM_CH];
      s_next.irq_mask = wdata_i[dgc_pkg::POS_MASK];
      s_next.trigger = wdata_i[dgc_pkg::POS_TRIGGER];
    end
    if (wr_qsel) begin
      s_next.qsel = wdata_i[NUM_QSEL-1:0];
    end
    if (wr_mode) begin
      s_next.mode = wdata_i[dgc_pkg::POS_MODE];
    end
    // Write-one-to-clear; a set in the same cycle wins.
    if (wr_status) begin
      if (wdata_i[dgc_pkg::POS_DONE]) s_next.done_flag = 1'b0;
      if (wdata_i[dgc_pkg::POS_FAILED]) s_next.fail_flag = 1'b0;
    end
    case (s_reg.ar_st)
      DGC_IDLE: begin
        if (s_reg.trigger) begin
          s_next.load = 1'b1;
          s_next.qsel_out = s_reg.qsel;
          s_next.cmd_out = ch_cmd_i;
          s_next.ar_st = DGC_BUSY;
        end
      end
      DGC_BUSY: begin
        if (action_done_i || action_fail_i) begin
          // Building on the cleared copy keeps a clear of the other flag; fail wins over done.
          s_next.done_flag = s_next.done_flag | (action_done_i & !action_fail_i);
          s_next.fail_flag = s_next.fail_flag | action_fail_i;
          s_next.ar_st = DGC_IDLE;
        end
      end
      default: s_next.ar_st = DGC_IDLE;
    endcase
    if (rd_i) begin
      case (addr_i)
        dgc_pkg::CMD_OFFSET: begin
          // Self-clearing bits read back as zero; reserved ranges are zero too.
          s_next.rdata[dgc_pkg::POS_MASK] = s_reg.irq_mask;
        end
        dgc_pkg::QSEL_OFFSET: s_next.rdata[NUM_QSEL-1:0] = s_reg.qsel;
        dgc_pkg::STATUS_OFFSET: begin
          s_next.rdata[dgc_pkg::POS_DONE] = s_reg.done_flag;
          s_next.rdata[dgc_pkg::POS_FAILED] = s_reg.fail_flag;
        end
        dgc_pkg::MODE_OFFSET: s_next.rdata[dgc_pkg::POS_MODE] = s_reg.mode;
        default: s_next.rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge sys_clk_i or negedge rst_b) begin
    if (!rst_b) begin
      s_reg.tx_poll <= '0;
      s_reg.irq_mask <= dgc_pkg::MASK_RESET;
      s_reg.trigger <= 1'b0;
      s_reg.qsel <= '0;
      s_reg.mode <= dgc_pkg::MODE_RESET;
      s_reg.done_flag <= 1'b0;
      s_reg.fail_flag <= 1'b0;
      s_reg.ar_st <= DGC_IDLE;
      s_reg.load <= 1'b0;
      s_reg.qsel_out <= '0;
      s_reg.cmd_out <= 4'h0;
      s_reg.rdata <= 32'h0;
    end else begin
      s_reg.tx_poll <= s_next.tx_poll;
      s_reg.irq_mask <= s_next.irq_mask;
      s_reg.trigger <= s_next.trigger;
      s_reg.qsel <= s_next.qsel;
      s_reg.mode <= s_next.mode;
      s_reg.done_flag <= s_next.done_flag;
      s_reg.fail_flag <= s_next.fail_flag;
      s_reg.ar_st <= s_next.ar_st;
      s_reg.load <= s_next.load;
      s_reg.qsel_out <= s_next.qsel_out;
      s_reg.cmd_out <= s_next.cmd_out;
      s_reg.rdata <= s_next.rdata;
    end
  end
  assign rdata_o = s_reg.rdata;
  assign queue_load_o = s_reg.load;
  assign queue_sel_o = s_reg.qsel_out;
  assign ch_cmd_o = s_reg.cmd_out;
  assign request_irq_mask_o = s_reg.irq_mask;
  a_poll_selfclr: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (wr_cmd ##1 !wr_cmd) |=> (s_reg.tx_poll == '0)) else $error("poll bits did not self clear");
  a_poll_mode: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (s_reg.mode != dgc_pkg::MODE_HOLD) |-> (poll_go == '0)) else $error("poll honoured outside hold mode");
  a_cmd_reserved: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (rd_i && addr_i == dgc_pkg::CMD_OFFSET) |=> (rdata_o[31:10] == 22'h0 && rdata_o[8:0] == 9'h0))
    else $error("reserved command bits read nonzero");
  a_mask_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    wr_cmd |=> (request_irq_mask_o == $past(wdata_i[dgc_pkg::POS_MASK]))) else $error("mask not stored");
  a_trigger_load: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (wr_cmd && wdata_i[dgc_pkg::POS_TRIGGER] && s_reg.ar_st == DGC_IDLE) |=> ##1 queue_load_o)
    else $error("action request did not start");
  a_no_trigger: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    queue_load_o |-> $past(s_reg.trigger)) else $error("queue load without trigger");
  a_done_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (s_reg.ar_st == DGC_BUSY && action_done_i && !action_fail_i) |=> s_reg.done_flag)
    else $error("done flag not set");
  a_fail_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (s_reg.ar_st == DGC_BUSY && action_fail_i) |=> s_reg.fail_flag) else $error("failed flag not set");

  a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    !rd_i
    |=> (rdata_o == 32'h0))
    else $error("read data not zero outside a read");
  a_poll_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    wr_cmd
    |=> (s_reg.tx_poll == $past(wdata_i[dgc_pkg::POS_POLL_LO +: NUM_CH])))
    else $error("poll bits not taken from the write");
  a_mode_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    wr_mode
    |=> (s_reg.mode == $past(wdata_i[dgc_pkg::POS_MODE])))
    else $error("control mode not stored");
  a_trigger_selfclr: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (s_reg.trigger && !wr_cmd)
    |=> !s_reg.trigger)
    else $error("trigger did not self clear");
  a_trigger_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (wr_cmd && !wdata_i[dgc_pkg::POS_TRIGGER])
    |=> !s_reg.trigger)
    else $error("zero written to trigger started a request");
  a_load_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    queue_load_o
    |=> !queue_load_o)
    else $error("queue load longer than one cycle");
  a_busy_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (s_reg.ar_st == DGC_BUSY)
    |=> !queue_load_o)
    else $error("request started while busy");
  a_load_busy: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    queue_load_o
    |-> (s_reg.ar_st == DGC_BUSY))
    else $error("queue load without busy state");
  a_load_cmd: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    queue_load_o
    |-> (ch_cmd_o == $past(ch_cmd_i)))
    else $error("channel command snapshot wrong");
  a_sel_held: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    !queue_load_o
    |-> ($stable(queue_sel_o) && $stable(ch_cmd_o)))
    else $error("queue or command outputs moved without a request");
  a_load_qsel: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    queue_load_o
    |-> (queue_sel_o == $past(s_reg.qsel)))
    else $error("queue select snapshot wrong");
  a_qsel_write: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    wr_qsel
    |=> (s_reg.qsel == $past(wdata_i[NUM_QSEL-1:0])))
    else $error("queue select not stored");
  a_mask_held: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    !wr_cmd
    |=> $stable(request_irq_mask_o))
    else $error("mask changed without a write");
  a_mask_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    rd_cmd
    |=> (rdata_o[dgc_pkg::POS_MASK] == $past(s_reg.irq_mask)))
    else $error("mask read back wrong");
  a_done_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (wr_status && wdata_i[dgc_pkg::POS_DONE] && !(s_reg.ar_st == DGC_BUSY && action_done_i && !action_fail_i))
    |=> !s_reg.done_flag)
    else $error("done flag not cleared");
  a_fail_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (wr_status && wdata_i[dgc_pkg::POS_FAILED] && !(s_reg.ar_st == DGC_BUSY && action_fail_i))
    |=> !s_reg.fail_flag)
    else $error("failed flag not cleared");
  a_flag_excl: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (s_reg.ar_st == DGC_BUSY && action_fail_i && !s_reg.done_flag)
    |=> !s_reg.done_flag)
    else $error("done flag set on a failed request");
  a_status_read: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    rd_status
    |=> (rdata_o[dgc_pkg::POS_DONE] == $past(s_reg.done_flag) &&
      rdata_o[dgc_pkg::POS_FAILED] == $past(s_reg.fail_flag)))
    else $error("status flags read back wrong");
  a_busy_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
    (s_reg.ar_st == DGC_BUSY && !action_done_i && !action_fail_i)
    |=> (s_reg.ar_st == DGC_BUSY))
    else $error("request ended without a result");

  // Per-channel checks rebuild the poll gate from tx_poll, halted and mode and watch fetch_req_o, so a broken poll_go gate shows here.
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chk
      a_poll_honoured: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (s_reg.tx_poll[g] && ch_halted[g] && s_reg.mode == dgc_pkg::MODE_HOLD)
        |=> fetch_req_o[g])
        else $error("poll on halted channel not honoured");
      a_poll_blocked: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (s_reg.tx_poll[g] && ch_halted[g] && s_reg.mode != dgc_pkg::MODE_HOLD)
        |=> !fetch_req_o[g])
        else $error("poll acted outside hold mode");
      a_poll_dropped: assert property (@(posedge sys_clk_i) disable iff (!rst_b)
        (s_reg.tx_poll[g] && !ch_halted[g] && !fetch_req_o[g])
        |=> !fetch_req_o[g])
        else $error("poll on running channel started a fetch");
    end
  endgenerate
endmodule : dgc_command

// file: pkg/dgc_pkg.sv
package dgc_pkg;
  localparam logic [3:0] CMD_OFFSET = 4'h0;
  localparam logic [3:0] QSEL_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;
  localparam logic [3:0] MODE_OFFSET = 4'hc;
  localparam int POS_TRIGGER = 0;
  localparam int POS_MASK = 9;
  localparam int POS_POLL_LO = 10;
  localparam int POS_DONE = 0;
  localparam int POS_FAILED = 1;
  localparam int POS_MODE = 0;
  localparam int NUM_CH = 4;
  localparam int NUM_QSEL = 9;
  localparam logic MASK_RESET = 1'b1;
  localparam logic MODE_RESET = 1'b0;
  localparam logic MODE_HOLD = 1'b0;
endpackage : dgc_pkg

// file: core/dgc_tx_channel.sv
`timescale 1ns/1ns
// Transmit channel poll sequencer for one channel.
module dgc_tx_channel (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Control
  input wire logic poll_i,
  input wire logic hold_seen_i,
  // Descriptor fetch
  output logic fetch_req_o,
  input wire logic fetch_done_i,
  input wire logic fetch_hold_i,
  // Status
  output logic halted_o,
  output logic advance_o
);
  typedef enum logic [2:0] {
    DGC_RUN = 3'b001,
    DGC_HALT = 3'b010,
    DGC_FETCH = 3'b100
  } dgc_ch_state_e;
  typedef struct packed {
    dgc_ch_state_e st;
    logic adv;
  } dgc_ch_s;
  dgc_ch_s s_reg, s_next;
  always_comb begin
    s_next = s_reg;
    s_next.adv = 1'b0;
    case (s_reg.st)
      DGC_RUN: begin
        if (hold_seen_i) begin
          s_next.st = DGC_HALT;
        end
      end
      DGC_HALT: begin
        if (poll_i) begin
          s_next.st = DGC_FETCH;
        end
      end
      DGC_FETCH: begin
        if (fetch_done_i) begin
          s_next.st = fetch_hold_i ? DGC_HALT : DGC_RUN;
          s_next.adv = !fetch_hold_i;
        end
      end
      default: s_next.st = DGC_RUN;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_reg <= '{st: DGC_RUN, adv: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end
  assign fetch_req_o = (s_reg.st == DGC_FETCH);
  assign halted_o = (s_reg.st == DGC_HALT);
  assign advance_o = s_reg.adv;
  a_poll_fetch: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (halted_o && poll_i) |=> fetch_req_o) else $error("poll on halted channel did not fetch");
  a_poll_ignored: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (s_reg.st == DGC_RUN && !hold_seen_i) |=> !fetch_req_o) else $error("poll acted while running");
endmodule : dgc_tx_channel

// file: bench/dma_global_command_low_test.sv
`timescale 1ns/1ns
module dma_global_command_low_test;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic wr_i = 1'b0, rd_i = 1'b0, queue_load_o, request_irq_mask_o;
  logic [3:0] hold_seen_i = 4'h0, fetch_done_i = 4'h0, fetch_hold_i = 4'h0, ch_cmd_i = 4'h0;
  logic [3:0] fetch_req_o, advance_o, ch_cmd_o, cc;
  logic action_done_i = 1'b0, action_fail_i = 1'b0;
  logic [8:0] queue_sel_o, qs;
  int errors = 0, tests_run = 0, mask_m = 1, sel_m, cmd_m;
  dgc_command DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .hold_seen_i(hold_seen_i), .fetch_req_o(fetch_req_o),
    .fetch_done_i(fetch_done_i), .fetch_hold_i(fetch_hold_i), .advance_o(advance_o), .ch_cmd_i(ch_cmd_i),
    .queue_load_o(queue_load_o), .queue_sel_o(queue_sel_o), .ch_cmd_o(ch_cmd_o), .action_done_i(action_done_i),
    .action_fail_i(action_fail_i), .request_irq_mask_o(request_irq_mask_o));
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rc(input string what, input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(what, exp, rdata_o);
  endtask : rc
  // Samples just after each edge, the call's own edge first, so a one-cycle pulse is not missed.
  task automatic wt(input int k, input int ch, output logic seen);
    seen = 1'b0;
    repeat (8) begin
      #1;
      if (k == 2 && queue_load_o === 1'b1) begin
        qs = queue_sel_o;
        cc = ch_cmd_o;
      end
      if ((k == 0 ? fetch_req_o[ch] : k == 1 ? advance_o[ch] : queue_load_o) === 1'b1) seen = 1'b1;
      @(posedge sys_clk_i);
    end
  endtask : wt
  task automatic poll(input int ch, input logic mk, input logic rh, input logic exp);
    logic seen;
    if (mk) begin
      @(posedge sys_clk_i);
      hold_seen_i[ch] <= 1'b1;
      @(posedge sys_clk_i);
      hold_seen_i[ch] <= 1'b0;
    end
    wr(dgc_pkg::CMD_OFFSET, (32'(mask_m) << 9) | (32'h1 << (10 + ch)));
    wt(0, ch, seen);
    chk("fetch_req", 32'(exp), 32'(seen));
    if (seen) begin
      @(posedge sys_clk_i);
      fetch_done_i[ch] <= 1'b1;
      fetch_hold_i[ch] <= rh;
      @(posedge sys_clk_i);
      fetch_done_i[ch] <= 1'b0;
      wt(1, ch, seen);
      chk("advance", 32'(!rh), 32'(seen));
    end
  endtask : poll
  task automatic action(input logic fail);
    logic seen;
    sel_m = $urandom_range(511, 0);
    cmd_m = $urandom_range(15, 0);
    ch_cmd_i <= 4'(cmd_m);
    wr(dgc_pkg::QSEL_OFFSET, 32'(sel_m));
    wr(dgc_pkg::CMD_OFFSET, (32'(mask_m) << 9) | 32'h1);
    wt(2, 0, seen);
    chk("queue_load", 32'h1, 32'(seen));
    chk("queue_sel", 32'(sel_m), 32'(qs));
    chk("ch_cmd", 32'(cmd_m), 32'(cc));
    @(posedge sys_clk_i);
    action_fail_i <= fail;
    action_done_i <= !fail;
    @(posedge sys_clk_i);
    action_fail_i <= 1'b0;
    action_done_i <= 1'b0;
    rc("status", dgc_pkg::STATUS_OFFSET, fail ? 32'h2 : 32'h1);
    wr(dgc_pkg::STATUS_OFFSET, 32'h3);
    rc("status_clear", dgc_pkg::STATUS_OFFSET, 32'h0);
  endtask : action
  initial begin
    logic seen;
    void'($urandom(32'h9eca));
    repeat (5) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rc("cmd_reset", dgc_pkg::CMD_OFFSET, 32'h200);
    chk("irq_mask", 32'h1, 32'(request_irq_mask_o));
    rc("mode_reset", dgc_pkg::MODE_OFFSET, 32'h0);
    $display("test reset done");
    // Poll bits to running channels must be dropped and read back as zero.
    wr(dgc_pkg::CMD_OFFSET, 32'hffff_fdfe);
    mask_m = 0;
    wt(0, 0, seen);
    chk("no_fetch", 32'h0, 32'(fetch_req_o));
    chk("no_fetch_ch0", 32'h0, 32'(seen));
    rc("cmd_ones", dgc_pkg::CMD_OFFSET, 32'h0);
    chk("irq_mask", 32'h0, 32'(request_irq_mask_o));
    wr(dgc_pkg::CMD_OFFSET, 32'hffff_fffe);
    mask_m = 1;
    rc("cmd_mask", dgc_pkg::CMD_OFFSET, 32'h200);
    wr(4'h2, 32'hffff_ffff);
    rc("unmapped", 4'h2, 32'h0);
    $display("test bits done");
    for (int ch = 0; ch < 4; ch++) begin
      poll(ch, 1'b1, 1'b1, 1'b1);
      poll(ch, 1'b0, 1'b0, 1'b1);
      poll(ch, 1'b0, 1'b0, 1'b0);
    end
    $display("test poll done");
    poll(0, 1'b1, 1'b1, 1'b1);
    wr(dgc_pkg::MODE_OFFSET, 32'h1);
    poll(0, 1'b0, 1'b0, 1'b0);
    wr(dgc_pkg::MODE_OFFSET, 32'h0);
    poll(0, 1'b0, 1'b0, 1'b1);
    $display("test mode done");
    action(1'b0);
    action(1'b1);
    wr(dgc_pkg::CMD_OFFSET, 32'h200);
    wt(2, 0, seen);
    chk("no_load", 32'h0, 32'(seen));
    $display("test action done");
    print_verdict();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #2000000;
    errors++;
    print_verdict();
  end
endmodule : dma_global_command_low_test
